// ===== fcsf_pkg.sv
// Constants shared by the flash command status flag block.
// Assumes an APB master with 32-bit data and a single 10 MHz clock.
//
// Summary of operation
// - Writing one to complete flag launches command.
// - Complete flag resets zero, set after init.
// - Complete flag reads zero while command runs.
// - Error flags block launches until cleared.
// - Read during command sets collision flag.
// - Only a flash read during a command counts as collision.
// - Collision flag clears only by writing one.
// - Sequence violation or illegal command sets access error.
// - Access error clears only by writing one.
// - Protected program or erase sets violation flag.
// - Violation flag clears only by writing one.
// - Bits three to one read zero.
// - Command or reset error sets completion status.
// - Completion status bit is read only.
// - Completion status cleared during next command.
// - Busy blocks writes to the parameter register only.
// - Complete enable requests interrupt on complete flag.
// - Collision enable requests interrupt on collision.
`default_nettype none
package fcsf_pkg;
    localparam logic [11:0] STATUS_OFS = 12'h000;
    localparam logic [11:0] CONFIG_OFS = 12'h004;
    localparam logic [11:0] PARAM_OFS = 12'h008;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h00C;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h010;
    localparam int CMD_DONE_BIT = 7;
    localparam int RDCOL_BIT = 6;
    localparam int ACC_BIT = 5;
    localparam int PVIOL_BIT = 4;
    localparam int MGST_BIT = 0;
    localparam int CC_IE_BIT = 7;
    localparam int RC_IE_BIT = 6;
    localparam int EV_DONE = 0;
    localparam int EV_RDCOL = 1;
    localparam int EV_ERR = 2;
    localparam logic [7:0] CONFIG_WMASK = 8'hC0;
    localparam logic [7:0] PARAM_RESET = 8'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam int INIT_NS = 1000;
    localparam int CLK_NS = 100;
    localparam logic [3:0] INIT_CYCLES = 4'(INIT_NS / CLK_NS);
    localparam logic [3:0] CLEAR_CYCLES = 4'h2;
    typedef enum logic [1:0] {
        FCSF_INIT,
        FCSF_IDLE,
        FCSF_BUSY
    } fcsf_state_e;
endpackage
`default_nettype wire

// ===== fcsf_top.sv
// Status flags, launch control and registers of the flash sequencer.
// Assumes a command engine that reports done, errors and collisions as
// one-cycle pulses, and an APB master on the same clock.
`default_nettype none
module fcsf_top (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_init_error,
    input wire logic i_cmd_done,
    input wire logic i_cmd_error,
    input wire logic i_seq_violation,
    input wire logic i_illegal_cmd,
    input wire logic i_prot_violation,
    input wire logic i_flash_read,
    output logic o_cmd_launch,
    output logic o_cmd_abort,
    output logic [7:0] o_cmd_param,
    output logic o_read_data_bad,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        fcsf_pkg::fcsf_state_e st;
        logic [3:0] cnt;
        logic cc_flag;
        logic rdcol;
        logic acc;
        logic pviol;
        logic mgst;
        logic [7:0] cfg;
        logic [7:0] param;
        logic [2:0] ev;
        logic [2:0] mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic launch;
        logic abort;
        logic bad;
        logic irq;
    } fcsf_regs_s;

    fcsf_regs_s r_q;
    fcsf_regs_s r_d;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    logic acc_phase;
    logic wr;
    logic rd;
    logic [7:0] wb;
    assign acc_phase = psel && penable && !r_q.ready;
    assign wr = acc_phase && pwrite;
    assign rd = acc_phase && !pwrite;
    assign wb = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic busy;
        logic launch_ok;
        logic rdcol_ev;
        logic viol;
        logic [2:0] ev_set;
        busy = 1'b0;
        launch_ok = 1'b0;
        rdcol_ev = 1'b0;
        viol = 1'b0;
        ev_set = 3'h0;
        r_d = r_q;
        r_d.ready = acc_phase;
        r_d.err = 1'b0;
        r_d.launch = 1'b0;
        r_d.abort = 1'b0;
        r_d.bad = 1'b0;
        busy = r_q.st == fcsf_pkg::FCSF_BUSY;
        // Collisions are flagged even when the read arrives in the very
        // cycle the command ends, since arbitration already lost.
        rdcol_ev = busy && i_flash_read;
        r_d.bad = rdcol_ev;
        viol = busy && (i_seq_violation || i_illegal_cmd || i_prot_violation);
        unique case (r_q.st)
            fcsf_pkg::FCSF_INIT: begin
                r_d.cnt = r_q.cnt + 4'h1;
                if (r_q.cnt == fcsf_pkg::INIT_CYCLES - 4'h1) begin
                    r_d.st = fcsf_pkg::FCSF_IDLE;
                    r_d.cc_flag = 1'b1;
                    r_d.mgst = i_init_error;
                    ev_set[fcsf_pkg::EV_DONE] = 1'b1;
                end
            end
            fcsf_pkg::FCSF_IDLE: begin
                // A set error flag is checked before the launch, and a
                // write that clears it does not launch in the same access.
                launch_ok = wr && hit(paddr, fcsf_pkg::STATUS_OFS)
                    && wb[fcsf_pkg::CMD_DONE_BIT]
                    && !r_q.acc && !r_q.pviol;
                if (launch_ok) begin
                    r_d.st = fcsf_pkg::FCSF_BUSY;
                    r_d.cc_flag = 1'b0;
                    r_d.launch = 1'b1;
                    r_d.cnt = 4'h0;
                end
            end
            fcsf_pkg::FCSF_BUSY: begin
                if (r_q.cnt != fcsf_pkg::CLEAR_CYCLES) begin
                    r_d.cnt = r_q.cnt + 4'h1;
                end
                if (r_q.cnt == fcsf_pkg::CLEAR_CYCLES - 4'h1) begin
                    r_d.mgst = 1'b0;
                end
                if (viol || i_cmd_done) begin
                    r_d.st = fcsf_pkg::FCSF_IDLE;
                    r_d.cc_flag = 1'b1;
                    r_d.abort = viol;
                    ev_set[fcsf_pkg::EV_DONE] = 1'b1;
                    if (i_cmd_done && i_cmd_error) begin
                        r_d.mgst = 1'b1;
                    end
                end
            end
        endcase
        // Write-one clears come first so that a new event wins.
        if (wr && hit(paddr, fcsf_pkg::STATUS_OFS)) begin
            if (wb[fcsf_pkg::RDCOL_BIT]) r_d.rdcol = 1'b0;
            if (wb[fcsf_pkg::ACC_BIT]) r_d.acc = 1'b0;
            if (wb[fcsf_pkg::PVIOL_BIT]) r_d.pviol = 1'b0;
        end
        if (rdcol_ev) begin
            r_d.rdcol = 1'b1;
            ev_set[fcsf_pkg::EV_RDCOL] = 1'b1;
        end
        if (busy && (i_seq_violation || i_illegal_cmd)) begin
            r_d.acc = 1'b1;
            ev_set[fcsf_pkg::EV_ERR] = 1'b1;
        end
        if (busy && i_prot_violation) begin
            r_d.pviol = 1'b1;
            ev_set[fcsf_pkg::EV_ERR] = 1'b1;
        end
        if (wr && hit(paddr, fcsf_pkg::CONFIG_OFS)) begin
            r_d.cfg = wb & fcsf_pkg::CONFIG_WMASK;
        end
        // The parameter register is frozen while a command runs so the
        // engine never sees its operands change under it.
        if (wr && hit(paddr, fcsf_pkg::PARAM_OFS) && !busy) begin
            r_d.param = wb;
        end
        if (wr && hit(paddr, fcsf_pkg::IRQ_MASK_OFS)) begin
            r_d.mask = wb[2:0];
        end
        if (wr && hit(paddr, fcsf_pkg::IRQ_STAT_OFS)) begin
            r_d.ev = r_q.ev & ~wb[2:0];
        end
        r_d.ev = r_d.ev | ev_set;
        r_d.rdata = 32'h0000_0000;
        if (rd) begin
            if (hit(paddr, fcsf_pkg::STATUS_OFS)) begin
                r_d.rdata[fcsf_pkg::CMD_DONE_BIT] = r_q.cc_flag;
                r_d.rdata[fcsf_pkg::RDCOL_BIT] = r_q.rdcol;
                r_d.rdata[fcsf_pkg::ACC_BIT] = r_q.acc;
                r_d.rdata[fcsf_pkg::PVIOL_BIT] = r_q.pviol;
                r_d.rdata[fcsf_pkg::MGST_BIT] = r_q.mgst;
            end else if (hit(paddr, fcsf_pkg::CONFIG_OFS)) begin
                r_d.rdata[7:0] = r_q.cfg;
            end else if (hit(paddr, fcsf_pkg::PARAM_OFS)) begin
                r_d.rdata[7:0] = r_q.param;
            end else if (hit(paddr, fcsf_pkg::IRQ_STAT_OFS)) begin
                r_d.rdata[2:0] = r_q.ev;
            end else if (hit(paddr, fcsf_pkg::IRQ_MASK_OFS)) begin
                r_d.rdata[2:0] = r_q.mask;
            end
        end
        if (acc_phase && !(hit(paddr, fcsf_pkg::STATUS_OFS)
                || hit(paddr, fcsf_pkg::CONFIG_OFS)
                || hit(paddr, fcsf_pkg::PARAM_OFS)
                || hit(paddr, fcsf_pkg::IRQ_STAT_OFS)
                || hit(paddr, fcsf_pkg::IRQ_MASK_OFS))) begin
            r_d.err = 1'b1;
        end
        r_d.irq = (r_d.cc_flag && r_d.cfg[fcsf_pkg::CC_IE_BIT])
            || (r_d.rdcol && r_d.cfg[fcsf_pkg::RC_IE_BIT])
            || |(r_d.ev & r_d.mask);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r_q <= '0;
            r_q.st <= fcsf_pkg::FCSF_INIT;
            r_q.param <= fcsf_pkg::PARAM_RESET;
            r_q.mask <= fcsf_pkg::IRQ_MASK_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign prdata = r_q.rdata;
    assign pready = r_q.ready;
    assign pslverr = r_q.err;
    assign o_cmd_launch = r_q.launch;
    assign o_cmd_abort = r_q.abort;
    assign o_cmd_param = r_q.param;
    assign o_read_data_bad = r_q.bad;
    assign o_irq = r_q.irq;

endmodule
`default_nettype wire

// ===== fcsf_flags_chk.sv
// Port timing checks for the flash status flag block.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module fcsf_flags_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic i_seq_violation,
    input wire logic i_illegal_cmd,
    input wire logic i_prot_violation,
    input wire logic i_flash_read,
    input wire logic o_cmd_launch,
    input wire logic o_cmd_abort,
    input wire logic o_read_data_bad
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    a_launch_answer: assert property (o_cmd_launch |-> pready)
        else $error("launch off answer");
    a_launch_pulse: assert property (o_cmd_launch |=> !o_cmd_launch)
        else $error("launch too long");
    a_answer_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("answer late");
    a_answer_pulse: assert property (pready |=> !pready)
        else $error("answer too long");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("data outside answer");
    a_refuse_zero: assert property (
        pslverr |-> pready && prdata == 32'h0)
        else $error("bad refusal");
    a_bad_cause: assert property (
        o_read_data_bad |-> $past(i_flash_read))
        else $error("bad data flag");
    // Aborts come only from the three violation pulses, never on their own.
    a_abort_cause: assert property (o_cmd_abort |->
        $past(i_seq_violation || i_illegal_cmd || i_prot_violation))
        else $error("abort without cause");
endmodule
bind fcsf_top fcsf_flags_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_seq_violation(i_seq_violation),
    .i_illegal_cmd(i_illegal_cmd), .i_prot_violation(i_prot_violation),
    .i_flash_read(i_flash_read), .o_cmd_launch(o_cmd_launch),
    .o_cmd_abort(o_cmd_abort), .o_read_data_bad(o_read_data_bad));
`default_nettype wire

// ===== fcsf_top_tb.sv
// Bench for the flag block: APB tasks and engine event pulses.
// Assumes the block answers each access after one wait state.
`default_nettype none
module fcsf_top_tb;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, rst = 1, ps = 0, pe = 0, pw = 0, pr, se, slv, lau, bad, irq;
logic abt, ie = 0;
logic [11:0] pa = 12'h000;
logic [31:0] wd = 32'h0, prd, r, e;
logic [7:0] prm;
logic [5:0] ev = 6'h00;
int failures = 0, compares = 0, nl = 0, nb = 0, na = 0, n;
initial forever #50 clk = ~clk;
fcsf_top dut (.i_ref_clk(clk), .i_rst(rst), .psel(ps), .penable(pe),
    .pwrite(pw), .paddr(pa), .pwdata(wd), .prdata(prd), .pready(pr),
    .pslverr(se), .i_init_error(ie), .i_cmd_done(ev[0]),
    .i_cmd_error(ev[1]), .i_seq_violation(ev[2]), .i_illegal_cmd(ev[3]),
    .i_prot_violation(ev[4]), .i_flash_read(ev[5]), .o_cmd_launch(lau),
    .o_cmd_abort(abt), .o_cmd_param(prm), .o_read_data_bad(bad), .o_irq(irq));
always @(posedge clk) begin
    if (lau === 1'b1) nl++;
    if (abt === 1'b1) na++;
    if (bad === 1'b1) nb++;
end
////////////////////////////////////////
task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
        failures++;
        $display("[ERR] %0t seen %h want %h", $time, s, x);
    end
endtask
task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
// One idle edge after each access, so back-to-back calls never collide.
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    ps <= 1'b1;
    pw <= w;
    pa <= a;
    wd <= d;
    @(posedge clk) pe <= 1'b1;
    do begin
        @(posedge clk);
        k++;
    end while (pr !== 1'b1 && k < 20);
    if (k == 20) begin
        failures++;
        end_of_test;
    end
    r = prd;
    slv = se;
    ps <= 1'b0;
    pe <= 1'b0;
    @(posedge clk);
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
endtask
task automatic ci(input logic x);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, x});
endtask
task automatic pulse(input logic [5:0] v);
    ev <= v;
    @(posedge clk) ev <= 6'h00;
    // Two more edges let the pulse counters settle before any compare.
    repeat (2) @(posedge clk);
endtask
////////////////////////////////////////
initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h000, 32'h0);
    repeat (10) @(posedge clk);
    rd(12'h000, 32'h80);
    wr(12'h004, 32'hC0);
    ci(1'b1);
    wr(12'h008, 32'h33);
    wr(12'h000, 32'h80);
    rd(12'h000, 32'h0);
    chk(32'(nl), 32'h1);
    ci(1'b0);
    pulse(6'h20);
    chk(32'(nb), 32'h1);
    rd(12'h000, 32'h40);
    ci(1'b1);
    wr(12'h000, 32'h0);
    rd(12'h000, 32'h40);
    wr(12'h000, 32'h40);
    rd(12'h000, 32'h0);
    pulse(6'h03);
    rd(12'h000, 32'h81);
    wr(12'h000, 32'h0F);
    rd(12'h000, 32'h81);
    $display("launch test done");
    wr(12'h000, 32'h80);
    rd(12'h000, 32'h0);
    wr(12'h008, 32'h5A);
    chk({24'h0, prm}, 32'h33);
    for (int k = 0; k < 3; k++) begin
        e = (k < 2) ? 32'hA0 : 32'h90;
        if (k > 0) wr(12'h000, 32'h80);
        pulse(6'(6'h04 << k));
        rd(12'h000, e);
        n = nl;
        wr(12'h000, 32'h80);
        wr(12'h000, 32'h0);
        rd(12'h000, e);
        chk(32'(nl), 32'(n));
        wr(12'h000, e & 32'h30);
        rd(12'h000, 32'h80);
    end
    chk(32'(na), 32'h3);
    $display("error test done");
    rd(12'h020, 32'h0);
    chk({31'h0, slv}, 32'h1);
    wr(12'h004, 32'h0);
    rd(12'h00C, 32'h7);
    ci(1'b0);
    wr(12'h010, 32'h7);
    ci(1'b1);
    wr(12'h00C, 32'h7);
    rd(12'h00C, 32'h0);
    ci(1'b0);
    $display("irq test done");
    ie <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h000, 32'h0);
    repeat (10) @(posedge clk);
    rd(12'h000, 32'h81);
    $display("reset test done");
    end_of_test;
end
endmodule
`default_nettype wire
